/* File: bssf_params.svh */
// Constants for the status sentence framer: characters, tags, field shapes, timing
`ifndef BSSF_PARAMS_SVH
`define BSSF_PARAMS_SVH

// System clock and the housekeeping tick that times the periodic sentences
`define BSSF_CLK_HZ        125000000
`define BSSF_TICK_US       1000
`define BSSF_US_PER_S      1000000

// Punctuation and hex digit offsets
`define BSSF_CHAR_COMMA    8'h2c
`define BSSF_CHAR_CR       8'h0d
`define BSSF_CHAR_LF       8'h0a
`define BSSF_CHAR_ZERO     8'h30
`define BSSF_CHAR_ALPHA    8'h37
`define BSSF_DIGIT_TEN     4'ha

// Three-character sentence tags, first character in the top byte
`define BSSF_TAG_SENT_CAN  24'h434e32
`define BSSF_TAG_CHARGER   24'h435331
`define BSSF_TAG_PACK      24'h435631
`define BSSF_TAG_DIST      24'h445431
`define BSSF_TAG_LAST      2'h2

// Number of data fields per sentence kind
`define BSSF_NF_SENT_CAN   4'h5
`define BSSF_NF_CHARGER    4'h6
`define BSSF_NF_PACK       4'ha
`define BSSF_NF_DIST       4'hc

// Digits per field
`define BSSF_NIB_ID        5'h08
`define BSSF_NIB_FLAG      5'h01
`define BSSF_NIB_BYTE      5'h02
`define BSSF_NIB_HALF      5'h04
`define BSSF_NIB_WORD      5'h08
`define BSSF_DLC_MAX       4'h8

// Field indices inside sentences
`define BSSF_FI_ID         4'h0
`define BSSF_FI_EXT        4'h1
`define BSSF_FI_RTR        4'h2
`define BSSF_FI_DLC        4'h3
`define BSSF_FI_DATA       4'h4
`define BSSF_FI_CNT        4'h0
`define BSSF_FI_STAT       4'h1
`define BSSF_FI_SETV       4'h2
`define BSSF_FI_SETI       4'h3
`define BSSF_FI_ACTV       4'h4
`define BSSF_FI_ACTI       4'h5
`define BSSF_FI_VOLT       4'h0
`define BSSF_FI_AMP        4'h1
`define BSSF_FI_DIAG0      4'h2
`define BSSF_FI_SPEED      4'h0

// Request kind codes on the request port
`define BSSF_REQ_CHARGER   2'h0
`define BSSF_REQ_PACK      2'h1
`define BSSF_REQ_DIST      2'h2

// Transmit class codes; class none is never reported
`define BSSF_CLASS_NONE    2'h0

`endif

/* File: bssf_pkg.sv */
// Types shared by the status sentence framer
package bssf_pkg;
  typedef enum logic [1:0] {
    SK_SENT_CAN,
    SK_CHARGER,
    SK_PACK,
    SK_DIST
  } bssf_kind_e;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_TAG,
    ST_COMMA,
    ST_DIGIT,
    ST_CK_HI,
    ST_CK_LO,
    ST_CR,
    ST_LF
  } bssf_state_e;
endpackage

/* File: bssf_skid2.sv */
// Two-entry character buffer between the sentence sequencer and the serial sink
`timescale 1ns/1ps
module bssf_skid2 #(
  parameter int WIDTH = 8
) (
  input  wire logic             clock,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic      [WIDTH-1:0] out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);
  logic [WIDTH-1:0] tail;
  logic [1:0]       count;
  logic [1:0]       next_count;
  wire              push = in_valid & in_ready;
  wire              pop  = out_valid & out_ready;

  // Head is the output register so the sink sees flop outputs only
  assign in_ready   = (count != 2'h2);
  assign next_count = count + {1'b0, push} - {1'b0, pop};

  // Occupancy and valid move together
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      count     <= 2'h0;
      out_valid <= 1'b0;
    end else begin
      count     <= next_count;
      out_valid <= (next_count != 2'h0);
    end
  end

  // Head refills from tail on a pop with both entries held, otherwise from the input
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      out_data <= '0;
      tail     <= '0;
    end else begin
      if (push && (count == 2'h0 || (pop && count == 2'h1))) begin
        out_data <= in_data;
      end else if (pop && count == 2'h2) begin
        out_data <= tail;
      end
      if (push && (count == 2'h2 || (!pop && count == 2'h1))) begin
        tail <= in_data;
      end
    end
  end
endmodule

/* File: bms_status_sentence_framer.sv */
// Status sentence framer: builds text report sentences and streams them as characters
`timescale 1ns/1ps
`include "bssf_params.svh"
module bms_status_sentence_framer
  import bssf_pkg::*;
#(
  parameter int TICK_CYCLES = `BSSF_CLK_HZ / `BSSF_US_PER_S * `BSSF_TICK_US,
  parameter int PERIOD_W    = 16
) (
  input  wire logic                clock,
  input  wire logic                rst,
  // Transmitted CAN frame notification
  input  wire logic                forward_enable,
  input  wire logic                can_tx_valid,
  input  wire logic [1:0]          can_tx_class,
  input  wire logic [31:0]         can_tx_id,
  input  wire logic                can_tx_ext,
  input  wire logic                can_tx_rtr,
  input  wire logic [3:0]          can_tx_dlc,
  input  wire logic [63:0]         can_tx_data,
  output logic                     can_drop,
  // Requests decoded from the serial receiver
  input  wire logic                req_valid,
  input  wire logic [1:0]          req_kind,
  // Repetition intervals in ticks
  input  wire logic                sleep_mode,
  input  wire logic [PERIOD_W-1:0] active_period,
  input  wire logic [PERIOD_W-1:0] sleep_period,
  // Charger values
  input  wire logic [7:0]          chg_count,
  input  wire logic                chg_is_can,
  input  wire logic [7:0]          chg_status,
  input  wire logic [15:0]         chg_set_volt,
  input  wire logic [15:0]         chg_set_amp,
  input  wire logic                chg_act_volt_ok,
  input  wire logic [15:0]         chg_act_volt,
  input  wire logic                chg_act_amp_ok,
  input  wire logic [15:0]         chg_act_amp,
  // Pack values
  input  wire logic [31:0]         pack_volt,
  input  wire logic [15:0]         pack_amp,
  input  wire logic [7:0][15:0]    pack_diag,
  // Distance and energy values, index 0 is speed in its low half
  input  wire logic [11:0][31:0]   dist_field,
  // Character stream out
  output logic [7:0]               out_data,
  output logic                     out_valid,
  input  wire logic                out_ready
);
  localparam int TICK_W = $clog2(TICK_CYCLES + 1);

  bssf_state_e   state;
  bssf_kind_e    cur_kind;
  logic [23:0]   tag_sh;
  logic [1:0]    tag_cnt;
  logic [3:0]    fld;
  logic [63:0]   dig_sh;
  logic [4:0]    nib_left;
  logic [7:0]    csum;
  logic [TICK_W-1:0]   tick_cnt;
  logic                tick;
  logic [PERIOD_W-1:0] period_cnt;
  logic [3:0]    pend;
  // Latched frame, held until its sentence has gone out
  logic [31:0]   can_id;
  logic          can_ext;
  logic          can_rtr;
  logic [3:0]    can_dlc;
  logic [63:0]   can_data;

  // Field word: present, digit count, value aligned to the top nibble
  function automatic logic [69:0] field_word(input bssf_kind_e k, input logic [3:0] i);
    logic [69:0] w;
    w = '0;
    case (k)
      SK_SENT_CAN: begin
        if (i == `BSSF_FI_ID) begin
          w = {1'b1, `BSSF_NIB_ID, can_id, 32'h0};
        end else if (i == `BSSF_FI_EXT) begin
          w = {1'b1, `BSSF_NIB_FLAG, 3'h0, can_ext, 60'h0};
        end else if (i == `BSSF_FI_RTR) begin
          w = {1'b1, `BSSF_NIB_FLAG, 3'h0, can_rtr, 60'h0};
        end else if (i == `BSSF_FI_DLC) begin
          // Count is at most eight, so its decimal and hex digits agree
          w = {1'b1, `BSSF_NIB_FLAG, can_dlc, 60'h0};
        end else if (i == `BSSF_FI_DATA) begin
          w = {1'b1, can_dlc, 1'b0, can_data};
        end
      end
      SK_CHARGER: begin
        if (i == `BSSF_FI_CNT) begin
          w = {1'b1, `BSSF_NIB_BYTE, chg_count, 56'h0};
        end else if (i == `BSSF_FI_STAT) begin
          w = {chg_is_can, `BSSF_NIB_BYTE, chg_status, 56'h0};
        end else if (i == `BSSF_FI_SETV) begin
          w = {chg_is_can, `BSSF_NIB_HALF, chg_set_volt, 48'h0};
        end else if (i == `BSSF_FI_SETI) begin
          w = {chg_is_can, `BSSF_NIB_HALF, chg_set_amp, 48'h0};
        end else if (i == `BSSF_FI_ACTV) begin
          w = {chg_is_can & chg_act_volt_ok, `BSSF_NIB_HALF, chg_act_volt, 48'h0};
        end else if (i == `BSSF_FI_ACTI) begin
          w = {chg_is_can & chg_act_amp_ok, `BSSF_NIB_HALF, chg_act_amp, 48'h0};
        end
      end
      SK_PACK: begin
        if (i == `BSSF_FI_VOLT) begin
          w = {1'b1, `BSSF_NIB_WORD, pack_volt, 32'h0};
        end else if (i == `BSSF_FI_AMP) begin
          // Two's complement digits carry the sign of the current
          w = {1'b1, `BSSF_NIB_HALF, pack_amp, 48'h0};
        end else begin
          // Diagnostics pass through untouched; meaning is not fixed
          w = {1'b1, `BSSF_NIB_HALF, pack_diag[3'(i - `BSSF_FI_DIAG0)], 48'h0};
        end
      end
      default: begin
        if (i == `BSSF_FI_SPEED) begin
          w = {1'b1, `BSSF_NIB_HALF, dist_field[0][15:0], 48'h0};
        end else begin
          // Fields 1..11 are whole words in fixed order
          w = {1'b1, `BSSF_NIB_WORD, dist_field[i], 32'h0};
        end
      end
    endcase
    return w;
  endfunction

  function automatic logic [7:0] hex_char(input logic [3:0] d);
    return (d < `BSSF_DIGIT_TEN) ? (`BSSF_CHAR_ZERO + {4'h0, d}) : (`BSSF_CHAR_ALPHA + {4'h0, d});
  endfunction

  // Decode of the word for the field being opened
  wire [69:0] fw          = field_word(cur_kind, fld);
  wire        fw_present  = fw[69];
  wire [4:0]  fw_nibs     = fw[68:64];
  wire [63:0] fw_val      = fw[63:0];
  wire [3:0]  nfields     = (cur_kind == SK_SENT_CAN) ? `BSSF_NF_SENT_CAN :
                            (cur_kind == SK_CHARGER)  ? `BSSF_NF_CHARGER  :
                            (cur_kind == SK_PACK)     ? `BSSF_NF_PACK     : `BSSF_NF_DIST;

  // Character for this state; checksum covers all before its digits
  wire [7:0]  cur_char    = (state == ST_TAG)   ? tag_sh[23:16] :
                            (state == ST_COMMA) ? `BSSF_CHAR_COMMA :
                            (state == ST_DIGIT) ? hex_char(dig_sh[63:60]) :
                            (state == ST_CK_HI) ? hex_char(csum[7:4]) :
                            (state == ST_CK_LO) ? hex_char(csum[3:0]) :
                            (state == ST_CR)    ? `BSSF_CHAR_CR : `BSSF_CHAR_LF;
  wire        buf_ready;
  wire        emit        = (state != ST_IDLE) && buf_ready;
  wire        sum_char    = (state == ST_TAG) || (state == ST_COMMA) || (state == ST_DIGIT);
  wire        done        = emit && (state == ST_LF);

  // Arbitration: a pending frame report goes ahead of status sentences
  wire        start       = (state == ST_IDLE) && (pend != 4'h0);
  wire        pick_can    = pend[SK_SENT_CAN];
  wire        pick_chg    = !pick_can && pend[SK_CHARGER];
  wire        pick_pack   = !pick_can && !pick_chg && pend[SK_PACK];
  wire [3:0]  clr_mask    = {start && !pick_can && !pick_chg && !pick_pack, start && pick_pack,
                             start && pick_chg, done && (cur_kind == SK_SENT_CAN)};

  // Frame filter and capture slot
  wire        can_hit     = can_tx_valid && forward_enable &&
                            (can_tx_class != `BSSF_CLASS_NONE);
  wire        can_take    = can_hit && !pend[SK_SENT_CAN];
  wire [3:0]  dlc_clamp   = (can_tx_dlc > `BSSF_DLC_MAX) ? `BSSF_DLC_MAX : can_tx_dlc;

  // Periodic trigger and requests
  wire [PERIOD_W-1:0] period_sel = sleep_mode ? sleep_period : active_period;
  wire        period_hit  = tick && (period_sel != '0) && (period_cnt + 1'b1 >= period_sel);
  wire [3:0]  req_set     = {req_valid && (req_kind == `BSSF_REQ_DIST),
                             req_valid && (req_kind == `BSSF_REQ_PACK),
                             req_valid && (req_kind == `BSSF_REQ_CHARGER), 1'b0};
  wire [3:0]  set_mask    = req_set | {{3{period_hit}}, can_take};

  // Tick divider gives the interval time base
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      tick_cnt <= '0;
      tick     <= 1'b0;
    end else begin
      tick     <= (tick_cnt == TICK_W'(TICK_CYCLES - 1));
      tick_cnt <= (tick_cnt == TICK_W'(TICK_CYCLES - 1)) ? '0 : tick_cnt + 1'b1;
    end
  end

  // Interval counter restarts on every expiry
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      period_cnt <= '0;
    end else if (tick) begin
      period_cnt <= period_hit ? '0 : period_cnt + 1'b1;
    end
  end

  // Pending flags: a set in the clearing cycle is kept
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      pend <= 4'h0;
    end else begin
      pend <= (pend & ~clr_mask) | set_mask;
    end
  end

  // Frame latch; a frame arriving while the slot is full is reported as dropped
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      can_id   <= '0;
      can_ext  <= 1'b0;
      can_rtr  <= 1'b0;
      can_dlc  <= '0;
      can_data <= '0;
      can_drop <= 1'b0;
    end else begin
      can_drop <= can_hit && !can_take;
      if (can_take) begin
        can_id   <= can_tx_id;
        can_ext  <= can_tx_ext;
        can_rtr  <= can_tx_rtr;
        can_dlc  <= dlc_clamp;
        can_data <= can_tx_data;
      end
    end
  end

  // Sentence sequencer; values are read live when each field opens
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state    <= ST_IDLE;
      cur_kind <= SK_SENT_CAN;
      tag_sh   <= '0;
      tag_cnt  <= '0;
      fld      <= '0;
      dig_sh   <= '0;
      nib_left <= '0;
      csum     <= '0;
    end else begin
      if (emit && sum_char) begin
        csum <= csum + cur_char;
      end
      case (state)
        ST_IDLE: begin
          if (start) begin
            csum    <= '0;
            tag_cnt <= '0;
            state   <= ST_TAG;
            if (pick_can) begin
              cur_kind <= SK_SENT_CAN;
              tag_sh   <= `BSSF_TAG_SENT_CAN;
            end else if (pick_chg) begin
              cur_kind <= SK_CHARGER;
              tag_sh   <= `BSSF_TAG_CHARGER;
            end else if (pick_pack) begin
              cur_kind <= SK_PACK;
              tag_sh   <= `BSSF_TAG_PACK;
            end else begin
              cur_kind <= SK_DIST;
              tag_sh   <= `BSSF_TAG_DIST;
            end
          end
        end
        ST_TAG: begin
          if (emit) begin
            tag_sh  <= {tag_sh[15:0], 8'h00};
            tag_cnt <= tag_cnt + 1'b1;
            if (tag_cnt == `BSSF_TAG_LAST) begin
              fld   <= '0;
              state <= ST_COMMA;
            end
          end
        end
        ST_COMMA: begin
          if (emit) begin
            if (fld == nfields) begin
              state <= ST_CK_HI;
            end else if (fw_present && fw_nibs != 5'h00) begin
              dig_sh   <= fw_val;
              nib_left <= fw_nibs;
              state    <= ST_DIGIT;
            end else begin
              fld <= fld + 1'b1;  // Absent value leaves an empty field
            end
          end
        end
        ST_DIGIT: begin
          if (emit) begin
            dig_sh   <= {dig_sh[59:0], 4'h0};
            nib_left <= nib_left - 1'b1;
            if (nib_left == 5'h01) begin
              fld   <= fld + 1'b1;
              state <= ST_COMMA;
            end
          end
        end
        ST_CK_HI: begin
          if (emit) begin
            state <= ST_CK_LO;
          end
        end
        ST_CK_LO: begin
          if (emit) begin
            state <= ST_CR;
          end
        end
        ST_CR: begin
          if (emit) begin
            state <= ST_LF;
          end
        end
        default: begin
          if (emit) begin
            state <= ST_IDLE;
          end
        end
      endcase
    end
  end

  // Buffer absorbs a sink stall without losing a character
  bssf_skid2 #(
    .WIDTH (8)
  ) u_buf (
    .clock     (clock),
    .rst       (rst),
    .in_data   (cur_char),
    .in_valid  (state != ST_IDLE),
    .in_ready  (buf_ready),
    .out_data  (out_data),
    .out_valid (out_valid),
    .out_ready (out_ready)
  );
endmodule

/* File: bssf_checker.sv */
// Protocol checker for the sentence framer's character stream and frame reports
`timescale 1ns/1ps
module bssf_checker (
  input  wire logic       clock,
  input  wire logic       rst,
  input  wire logic       forward_enable,
  input  wire logic       can_tx_valid,
  input  wire logic [1:0] can_tx_class,
  input  wire logic       can_drop,
  input  wire logic       req_valid,
  input  wire logic [1:0] req_kind,
  input  wire logic [7:0] out_data,
  input  wire logic       out_valid,
  input  wire logic       out_ready
);
  logic took;
  logic ok_frame;
  logic after_cr;
  logic after_lf;
  // Decoded stream events
  assign took     = out_valid && out_ready;
  assign ok_frame = can_tx_valid && forward_enable && (can_tx_class != 2'h0);
  // Whether the last character taken was a terminator; it fixes which character may come next
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      after_cr <= 1'b0;
      after_lf <= 1'b0;
    end else if (took) begin
      after_cr <= (out_data == 8'h0d);
      after_lf <= (out_data == 8'h0a);
    end
  end
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  AST_HOLD: assert property (out_valid && !out_ready |=>
    out_valid && $stable(out_data))
    else $error("stalled character changed before it was taken");
  AST_CHARSET: assert property (out_valid |-> out_data inside
    {[8'h30:8'h39], [8'h41:8'h5a], 8'h2c, 8'h0d, 8'h0a}) else $error("character not allowed");
  AST_AFTER_CR: assert property (after_cr && out_valid |-> out_data == 8'h0a)
    else $error("line feed does not follow carriage return");
  AST_AFTER_LF: assert property (after_lf && out_valid |->
    out_data inside {8'h43, 8'h44}) else $error("sentence does not start with a tag");
  AST_FRAME: assert property (ok_frame |-> ##[1:1000] (took && out_data == 8'h4e))
    else $error("reportable frame not reported");
  AST_DROP_CAUSE: assert property (can_drop |-> $past(ok_frame))
    else $error("drop pulse without a reportable frame");
  AST_NO_DROP: assert property (can_tx_valid && !ok_frame |=> !can_drop)
    else $error("ignored frame caused a drop pulse");
  AST_REQ_CHG: assert property (req_valid && req_kind == 2'h0 |->
    ##[1:1000] (took && out_data == 8'h53)) else $error("charger request not answered");
  AST_REQ_PACK: assert property (req_valid && req_kind == 2'h1 |->
    ##[1:1000] (took && out_data == 8'h56)) else $error("pack request not answered");
  AST_REQ_DIST: assert property (req_valid && req_kind == 2'h2 |->
    ##[1:1000] (took && out_data == 8'h54)) else $error("distance request not answered");
  // Main scenarios reached
  cover property (can_drop);
  cover property (out_valid && !out_ready);
  cover property (took && out_data == 8'h0a);
endmodule

/* File: bssf_sink.sv */
// Serial host model: takes characters with random stalls and keeps them in order
`timescale 1ns/1ps
module bssf_sink (
  input  wire logic       clock,
  input  wire logic       rst,
  input  wire logic [7:0] out_data,
  input  wire logic       out_valid,
  output logic            out_ready,
  input  wire logic [6:0] stall_pct
);
  logic [7:0] rx_q[$];
  // Ready moves after the falling edge so the framer always sees it settled
  always @(negedge clock or posedge rst) begin
    if (rst) begin
      out_ready <= 1'b0;
    end else begin
      out_ready <= 7'($urandom % 100) >= stall_pct;
    end
  end
  // Stored as raw text; diagnostic fields are never interpreted
  always @(posedge clock) begin
    if (!rst && out_valid && out_ready) begin
      rx_q.push_back(out_data);
    end
  end
endmodule

/* File: tb_bms_status_sentence_framer.sv */
// Self-checking bench for the status sentence framer
`timescale 1ns/1ps
module tb_bms_status_sentence_framer;
  logic              clock, rst, forward_enable, can_tx_valid, can_tx_ext, can_tx_rtr;
  logic              can_drop, req_valid, sleep_mode, chg_is_can, chg_act_volt_ok;
  logic              chg_act_amp_ok, out_valid, out_ready;
  logic [1:0]        can_tx_class, req_kind;
  logic [3:0]        can_tx_dlc;
  logic [31:0]       can_tx_id, pack_volt;
  logic [63:0]       can_tx_data;
  logic [15:0]       active_period, sleep_period, chg_set_volt, chg_set_amp;
  logic [15:0]       chg_act_volt, chg_act_amp, pack_amp;
  logic [7:0]        chg_count, chg_status, out_data;
  logic [7:0][15:0]  pack_diag;
  logic [11:0][31:0] dist_field;
  logic [7:0]        exp_q[$], got_q[$];
  logic [6:0]        stall;
  int                n_fail, compares, drops;

  bms_status_sentence_framer #(.TICK_CYCLES(10), .PERIOD_W(16)) bms_status_sentence_framer_inst (
    .clock(clock), .rst(rst), .forward_enable(forward_enable), .can_tx_valid(can_tx_valid),
    .can_tx_class(can_tx_class), .can_tx_id(can_tx_id), .can_tx_ext(can_tx_ext),
    .can_tx_rtr(can_tx_rtr), .can_tx_dlc(can_tx_dlc), .can_tx_data(can_tx_data),
    .can_drop(can_drop), .req_valid(req_valid), .req_kind(req_kind), .sleep_mode(sleep_mode),
    .active_period(active_period), .sleep_period(sleep_period), .chg_count(chg_count),
    .chg_is_can(chg_is_can), .chg_status(chg_status), .chg_set_volt(chg_set_volt),
    .chg_set_amp(chg_set_amp), .chg_act_volt_ok(chg_act_volt_ok), .chg_act_volt(chg_act_volt),
    .chg_act_amp_ok(chg_act_amp_ok), .chg_act_amp(chg_act_amp), .pack_volt(pack_volt),
    .pack_amp(pack_amp), .pack_diag(pack_diag), .dist_field(dist_field), .out_data(out_data),
    .out_valid(out_valid), .out_ready(out_ready));
  bssf_sink bssf_sink_inst (.clock(clock), .rst(rst), .out_data(out_data),
    .out_valid(out_valid), .out_ready(out_ready), .stall_pct(stall));

  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  // Registered pulse, so sampling at the rising edge counts each one once
  always @(posedge clock) begin
    if (can_drop === 1'b1) drops++;
  end

  // Expected text is built character by character in exp_q
  function automatic void put_hex(input logic [31:0] v, input int n);
    for (int i = n - 1; i >= 0; i--) begin
      exp_q.push_back(v[i*4 +: 4] < 4'ha ? 8'h30 + v[i*4 +: 4] : 8'h37 + v[i*4 +: 4]);
    end
  endfunction
  function automatic void put_tag(input string s);
    exp_q.delete();
    for (int i = 0; i < s.len(); i++) exp_q.push_back(s[i]);
  endfunction
  function automatic void put_fld(input logic [31:0] v, input int n, input logic on);
    exp_q.push_back(8'h2c);
    if (on) put_hex(v, n);
  endfunction
  // Checksum covers every character up to and including its own comma
  function automatic void put_end();
    logic [7:0] sum;
    exp_q.push_back(8'h2c);
    sum = 8'h00;
    foreach (exp_q[i]) sum += exp_q[i];
    put_hex(32'(sum), 2);
    exp_q.push_back(8'h0d);
    exp_q.push_back(8'h0a);
  endfunction
  function automatic void exp_can();
    int n;
    n = can_tx_dlc > 8 ? 8 : int'(can_tx_dlc);
    put_tag("CN2");
    put_fld(can_tx_id, 8, 1'b1);
    put_fld(32'(can_tx_ext), 1, 1'b1);
    put_fld(32'(can_tx_rtr), 1, 1'b1);
    put_fld(32'(n), 1, 1'b1);
    exp_q.push_back(8'h2c);
    for (int b = 0; b < n; b++) put_hex(32'(can_tx_data[63-8*b -: 8]), 2);
    put_end();
  endfunction
  function automatic void exp_kind(input int k);
    put_tag(k == 0 ? "CS1" : k == 1 ? "CV1" : "DT1");
    if (k == 0) begin
      put_fld(32'(chg_count), 2, 1'b1);
      put_fld(32'(chg_status), 2, chg_is_can);
      put_fld(32'(chg_set_volt), 4, chg_is_can);
      put_fld(32'(chg_set_amp), 4, chg_is_can);
      put_fld(32'(chg_act_volt), 4, chg_is_can && chg_act_volt_ok);
      put_fld(32'(chg_act_amp), 4, chg_is_can && chg_act_amp_ok);
    end else if (k == 1) begin
      put_fld(pack_volt, 8, 1'b1);
      put_fld(32'(pack_amp), 4, 1'b1);
      for (int i = 0; i < 8; i++) put_fld(32'(pack_diag[i]), 4, 1'b1);
    end else begin
      put_fld(32'(dist_field[0][15:0]), 4, 1'b1);
      for (int i = 1; i < 12; i++)
        put_fld(dist_field[i], 8, 1'b1);
    end
    put_end();
  endfunction

  task automatic wrap_up();
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic chk_val(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (exp !== got) begin
      n_fail++;
      $display("wrong value %s expected %0h seen %0h", what, exp, got);
    end
  endtask
  // Waits for one whole sentence from the host model and compares it
  task automatic take(input string what);
    got_q.delete();
    repeat (4000) begin
      if (8'h0a inside {bssf_sink_inst.rx_q}) break;
      @(negedge clock);
    end
    if (!(8'h0a inside {bssf_sink_inst.rx_q})) begin
      n_fail++;
      wrap_up();
    end
    do got_q.push_back(bssf_sink_inst.rx_q.pop_front()); while (got_q[$] !== 8'h0a);
    compares++;
    for (int i = 0; i < exp_q.size(); i++) begin
      if (got_q.size() != exp_q.size() || got_q[i] !== exp_q[i]) begin
        n_fail++;
        $display("wrong value %s char %0d expected %h seen %h", what, i, exp_q[i], got_q[i]);
        break;
      end
    end
  endtask
  // Returns once the stream has been idle for a while, bounded
  task automatic settle();
    int q;
    q = 0;
    repeat (3000) begin
      @(negedge clock);
      q = out_valid ? 0 : q + 1;
      if (q == 60) break;
    end
  endtask
  task automatic frame(input logic [1:0] cls, input logic [3:0] dlc);
    @(negedge clock);
    can_tx_valid = 1'b1;
    can_tx_class = cls;
    can_tx_dlc = dlc;
    {can_tx_id, can_tx_data} = {$urandom, $urandom, $urandom};
    {can_tx_ext, can_tx_rtr} = 2'($urandom);
    @(negedge clock);
    can_tx_valid = 1'b0;
  endtask
  task automatic req(input logic [1:0] k);
    @(negedge clock);
    req_valid = 1'b1;
    req_kind = k;
    @(negedge clock);
    req_valid = 1'b0;
  endtask
  task automatic shake();
    {chg_count, chg_status, chg_set_volt, chg_set_amp} = 48'({$urandom, $urandom});
    {chg_act_volt, chg_act_amp, pack_amp} = 48'({$urandom, $urandom});
    {chg_is_can, chg_act_volt_ok, chg_act_amp_ok} = 3'($urandom);
    pack_volt = $urandom;
    for (int i = 0; i < 8; i++) pack_diag[i] = 16'($urandom);
    for (int i = 0; i < 12; i++) dist_field[i] = $urandom;
  endtask

  initial begin
    void'($urandom(68021));
    stall = 7'(10 + $urandom % 30);
    rst = 1'b1;
    {forward_enable, can_tx_valid, can_tx_ext, can_tx_rtr, req_valid, sleep_mode} = '0;
    {can_tx_class, req_kind, can_tx_dlc, can_tx_id, can_tx_data} = '0;
    {active_period, sleep_period} = '0;
    shake();
    repeat (4) @(negedge clock);
    rst = 1'b0;
    forward_enable = 1'b1;
    // Requested status sentences with fresh random values each round
    repeat (6) begin
      shake();
      for (int k = 0; k < 3; k++) begin
        req(2'(k));
        exp_kind(k);
        take("status");
      end
    end
    // Every reported class, byte counts 0, 8 and clamped 15 first
    for (int i = 0; i < 9; i++) begin
      frame(2'(i % 3 + 1), i == 0 ? 4'h0 : i == 1 ? 4'h8 : i == 2 ? 4'hf : 4'($urandom % 9));
      exp_can();
      take("frame");
    end
    // Second frame while the slot is still full is lost with a pulse
    frame(2'h2, 4'h8);
    exp_can();
    frame(2'h3, 4'h1);
    take("kept frame");
    settle();
    chk_val("drops", 1, drops);
    // Unreported class, forwarding off and an unused request kind stay silent
    frame(2'h0, 4'h2);
    forward_enable = 1'b0;
    frame(2'h1, 4'h2);
    req(2'h3);
    settle();
    chk_val("silent chars", 0, bssf_sink_inst.rx_q.size());
    chk_val("drops", 1, drops);
    forward_enable = 1'b1;
    // Periodic output in active then sleep mode, charger first by priority
    active_period = 16'(60 + $urandom % 20);
    for (int m = 0; m < 2; m++) begin
      for (int k = 0; k < 3; k++) begin
        exp_kind(k);
        take("periodic");
      end
      sleep_mode = 1'b1;
      {active_period, sleep_period} = {16'h0, 16'(80 + $urandom % 20)};
    end
    {active_period, sleep_period} = '0;
    settle();
    bssf_sink_inst.rx_q.delete();
    // Reset in mid-sentence, then a clean answer
    req(2'h2);
    repeat (30) @(negedge clock);
    rst = 1'b1;
    @(negedge clock);
    rst = 1'b0;
    bssf_sink_inst.rx_q.delete();
    req(2'h1);
    exp_kind(1);
    take("after reset");
    wrap_up();
  end
endmodule

bind bms_status_sentence_framer bssf_checker bssf_checker_inst (
  .clock(clock), .rst(rst), .forward_enable(forward_enable), .can_tx_valid(can_tx_valid),
  .can_tx_class(can_tx_class), .can_drop(can_drop), .req_valid(req_valid),
  .req_kind(req_kind), .out_data(out_data), .out_valid(out_valid), .out_ready(out_ready));
